// [hdl/irc_car_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface irc_car_if;
  logic       on;
  logic       period_sel;
  logic [3:0] duty_sel;
  logic [1:0] tau_sel;
  logic       running;
  logic       carrier;
  logic       period_start;
  logic       tau_start;
  logic [6:0] cnt;
  logic [4:0] tau_cnt;

  modport gen (input on, period_sel, duty_sel, tau_sel,
               output running, carrier, period_start, tau_start, cnt, tau_cnt);
  modport ctl (output on, period_sel, duty_sel, tau_sel,
               input running, carrier, period_start, tau_start, cnt, tau_cnt);
endinterface : irc_car_if

`default_nettype wire

// [hdl/irc_carrier.sv]
`timescale 1ns/1ps
`default_nettype none

module irc_carrier
  import irc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  irc_car_if.gen   car
);

  typedef struct packed {
    logic       run;
    logic [6:0] cnt;
    logic [4:0] tau_cnt;
  } irc_car_state_t;

  irc_car_state_t s_r;
  irc_car_state_t s_nxt;
  logic [6:0]     period;
  logic [5:0]     ratio;
  logic           wrap;
  logic           tau_end;

  // ===========================================================================
  // divider and reference-cycle counter
  // ===========================================================================
  always_comb begin
    period  = car.period_sel ? PERIOD_96 : PERIOD_64;
    ratio   = irc_tau_ratio(car.tau_sel);
    // >= keeps the count bounded if the period is changed mid-run
    wrap    = s_r.run && (s_r.cnt >= period - 7'h01);
    tau_end = wrap && ({1'b0, s_r.tau_cnt} >= ratio - 6'h01);
    s_nxt   = s_r;
    if (!s_r.run) begin
      if (car.on) begin
        s_nxt.run     = 1'b1;
        s_nxt.cnt     = 7'h00;
        s_nxt.tau_cnt = 5'h00;
      end
    end else if (wrap) begin
      s_nxt.cnt     = 7'h00;
      s_nxt.tau_cnt = tau_end ? 5'h00 : s_r.tau_cnt + 5'h01;
      // stopping only on a reference-cycle edge avoids a clipped burst
      if (tau_end && !car.on) begin
        s_nxt.run = 1'b0;
      end
    end else begin
      s_nxt.cnt = s_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign car.running      = s_r.run;
  assign car.cnt          = s_r.cnt;
  assign car.tau_cnt      = s_r.tau_cnt;
  assign car.period_start = s_r.run && (s_r.cnt == 7'h00);
  assign car.tau_start    = car.period_start && (s_r.tau_cnt == 5'h00);
  assign car.carrier      = s_r.run && (s_r.cnt < irc_carrier_high(car.period_sel, car.duty_sel));

  // ===========================================================================
  // checks
  // ===========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  period_wrap_a: assert property (wrap && car.on |=> s_r.cnt == 7'h00)
    else $error("carrier period did not wrap");
  suppress_96_a: assert property (car.period_sel && car.duty_sel > DUTY_MAX_96 |-> !car.carrier)
    else $error("carrier not suppressed");
  duty_64_a: assert property (s_r.run && !car.period_sel && s_r.cnt == 7'h1f |-> car.carrier == (car.duty_sel >= DUTY_MAX_64))
    else $error("divide-by-64 duty wrong");
  stop_tau_a: assert property ($fell(s_r.run) |-> $past(s_r.cnt) >= $past(period) - 7'h01 && $past(s_r.tau_cnt) == 5'($past(ratio) - 6'h01))
    else $error("generator stopped off a reference edge");

  stop_seen_c: cover property ($fell(s_r.run));

endmodule : irc_carrier

`default_nettype wire

// [hdl/irc_pkg.sv]
`default_nettype none

package irc_pkg;

  // ===========================================================================
  // register map (byte addresses, one aligned word each)
  // ===========================================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_BURST  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // ===========================================================================
  // control and burst word fields
  // ===========================================================================
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_GATE_BIT = 1;
  localparam int CTRL_PSEL_BIT = 2;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_TSEL_LSB = 8;
  localparam int BURST_LEN_LSB = 0;
  localparam int BURST_PND_BIT = 2;
  localparam int BURST_REM_LSB = 4;

  // ===========================================================================
  // reset values
  // ===========================================================================
  localparam logic       CTRL_ON_RST   = 1'h1;
  localparam logic       CTRL_GATE_RST = 1'h0;
  localparam logic       CTRL_PSEL_RST = 1'h0;
  localparam logic [3:0] CTRL_DUTY_RST = 4'h0;
  localparam logic [1:0] CTRL_TSEL_RST = 2'h0;

  // ===========================================================================
  // timing
  // ===========================================================================
  localparam logic [6:0] PERIOD_64   = 7'h40;
  localparam logic [6:0] PERIOD_96   = 7'h60;
  localparam logic [6:0] HI_STEP_64  = 7'h08;
  localparam logic [6:0] HI_STEP_96  = 7'h04;
  localparam logic [3:0] DUTY_MAX_64 = 4'h3;
  localparam logic [3:0] DUTY_MAX_96 = 4'hb;
  localparam logic [5:0] TAU_DIV_12  = 6'h0c;
  localparam logic [5:0] TAU_DIV_16  = 6'h10;
  localparam logic [5:0] TAU_DIV_20  = 6'h14;
  localparam logic [5:0] TAU_DIV_32  = 6'h20;
  localparam logic [5:0] INIT_CYCLES = 6'h20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================================
  // decoders shared by generator and checks
  // ===========================================================================
  function automatic logic [6:0] irc_carrier_high(input logic psel, input logic [3:0] duty);
    logic [3:0] d;
    d = duty;
    if (!psel) begin
      if (d > DUTY_MAX_64) begin
        d = DUTY_MAX_64;
      end
      irc_carrier_high = 7'({3'h0, d} + 7'h01) * HI_STEP_64;
    end else if (d > DUTY_MAX_96) begin
      irc_carrier_high = 7'h00;
    end else begin
      irc_carrier_high = 7'({3'h0, d} + 7'h01) * HI_STEP_96;
    end
  endfunction : irc_carrier_high

  function automatic logic [5:0] irc_tau_ratio(input logic [1:0] sel);
    unique case (sel)
      2'h0: irc_tau_ratio = TAU_DIV_12;
      2'h1: irc_tau_ratio = TAU_DIV_16;
      2'h2: irc_tau_ratio = TAU_DIV_20;
      2'h3: irc_tau_ratio = TAU_DIV_32;
    endcase
  endfunction : irc_tau_ratio

endpackage : irc_pkg

`default_nettype wire

// [hdl/irc_top.sv]
// Overview of operation
// - pin is low after reset and whenever transmission is stopped
// - carrier period is 64 clocks for select 0, 96 for select 1
// - divide-by-64: duty codes 0 to 3 give 1/8 to 4/8 high time
// - divide-by-96: duty code n up to 11 gives (n+1)/24 high time
// - divide-by-96 with duty code 12 or more keeps output off
// - divide-by-64 with duty code 4 or more acts as code 3
// - period and duty settings writable any time, kept until reset
// - writing on bit 1 starts carrier, writing 0 stops it
// - reset sets on bit; it must not be cleared for 32 cycles
// - gate bit 1 passes carrier to the pin, 0 drives pin low except during a burst
// - gated output starts only at a carrier period start
// - reference cycle divides carrier; burst lasts 0 to 3 cycles
// - with no burst requested, output follows only the gate bit
// - reference ratio codes 0..3 give carrier /12, /16, /20, /32
// - clearing the on bit stops the generator at a reference edge
// - gate bit forces carrier out regardless of burst timing
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module irc_top
  import irc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic                   ir_tx_pin_o
);

  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W must be at least 4");
  end

  // ===========================================================================
  // state
  // ===========================================================================
  typedef struct packed {
    logic        on;
    logic        gate;
    logic        psel;
    logic [3:0]  duty;
    logic [1:0]  tsel;
    logic        gate_act;
    logic        burst_pend;
    logic [1:0]  burst_len;
    logic [1:0]  burst_rem;
    logic        pin;
    logic [5:0]  init_cnt;
    logic        aw_got;
    logic [3:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } irc_top_state_t;

  irc_top_state_t s_r;
  irc_top_state_t s_nxt;
  logic           aw_fire;
  logic           w_fire;
  logic           ar_fire;
  logic           gate_eff;

  irc_car_if car ();

  irc_carrier u_carrier (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .car       (car)
  );

  assign car.on         = s_r.on;
  assign car.period_sel = s_r.psel;
  assign car.duty_sel   = s_r.duty;
  assign car.tau_sel    = s_r.tsel;

  assign s_axi_awready_o = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready_o  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready_o = !s_r.rvalid;
  assign s_axi_bvalid_o  = s_r.bvalid;
  assign s_axi_bresp_o   = s_r.bresp;
  assign s_axi_rvalid_o  = s_r.rvalid;
  assign s_axi_rdata_o   = s_r.rdata;
  assign s_axi_rresp_o   = s_r.rresp;
  assign ir_tx_pin_o     = s_r.pin;

  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire  = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

  // ===========================================================================
  // next state
  // ===========================================================================
  always_comb begin
    s_nxt = s_r;

    // bus channels: address and data are latched independently
    if (aw_fire) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr_i[3:0];
    end
    if (w_fire) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata_i;
      s_nxt.wstrb = s_axi_wstrb_i;
    end
    if (s_r.bvalid && s_axi_bready_i) begin
      s_nxt.bvalid = 1'b0;
    end

    if (s_r.init_cnt != 6'h00) begin
      s_nxt.init_cnt = s_r.init_cnt - 6'h01;
    end

    // register write, one cycle after both halves are held
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      unique case (s_r.aw_addr)
        REG_CTRL: begin
          if (s_r.wstrb[0]) begin
            // clears are ignored while the generator is initialising
            s_nxt.on   = s_r.wdata[CTRL_ON_BIT] || (s_r.init_cnt != 6'h00);
            s_nxt.gate = s_r.wdata[CTRL_GATE_BIT];
            s_nxt.psel = s_r.wdata[CTRL_PSEL_BIT];
            s_nxt.duty = s_r.wdata[CTRL_DUTY_LSB +: 4];
          end
          if (s_r.wstrb[1]) begin
            s_nxt.tsel = s_r.wdata[CTRL_TSEL_LSB +: 2];
          end
        end
        REG_BURST: begin
          if (s_r.wstrb[0]) begin
            s_nxt.burst_len  = s_r.wdata[BURST_LEN_LSB +: 2];
            s_nxt.burst_pend = 1'b1;
          end
        end
        REG_STATUS: begin
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // register read
    if (s_r.rvalid && s_axi_rready_i) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr_i[3:0])
        REG_CTRL: begin
          s_nxt.rdata[CTRL_ON_BIT]        = s_r.on;
          s_nxt.rdata[CTRL_GATE_BIT]      = s_r.gate;
          s_nxt.rdata[CTRL_PSEL_BIT]      = s_r.psel;
          s_nxt.rdata[CTRL_DUTY_LSB +: 4] = s_r.duty;
          s_nxt.rdata[CTRL_TSEL_LSB +: 2] = s_r.tsel;
        end
        REG_BURST: begin
          s_nxt.rdata[BURST_LEN_LSB +: 2] = s_r.burst_len;
          s_nxt.rdata[BURST_PND_BIT]      = s_r.burst_pend;
          s_nxt.rdata[BURST_REM_LSB +: 2] = s_r.burst_rem;
        end
        REG_STATUS: begin
          s_nxt.rdata[3:0] = {s_r.init_cnt != 6'h00, s_r.burst_rem != 2'h0, s_r.pin, car.running};
        end
        default: begin
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // burst timing: a request waits for the next reference edge
    if (!s_r.on) begin
      s_nxt.burst_pend = 1'b0;
      s_nxt.burst_len  = 2'h0;
    end
    if (!car.running) begin
      s_nxt.burst_rem = 2'h0;
    end else if (car.tau_start) begin
      if (s_nxt.burst_pend) begin
        s_nxt.burst_rem  = s_nxt.burst_len;
        s_nxt.burst_pend = 1'b0;
      end else if (s_r.burst_rem != 2'h0) begin
        s_nxt.burst_rem = s_r.burst_rem - 2'h1;
      end
    end

    // gate opens only at a period start so the first pulse is whole,
    // but closes at once
    gate_eff       = s_r.gate && (s_r.gate_act || car.period_start);
    s_nxt.gate_act = gate_eff && car.running;
    s_nxt.pin      = car.carrier && (gate_eff || s_nxt.burst_rem != 2'h0);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '{on: CTRL_ON_RST, gate: CTRL_GATE_RST, psel: CTRL_PSEL_RST,
               duty: CTRL_DUTY_RST, tsel: CTRL_TSEL_RST, init_cnt: INIT_CYCLES,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ===========================================================================
  // checks
  // ===========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  pin_low_off_a: assert property (!car.running |=> !s_r.pin)
    else $error("pin high while generator stopped");
  gate_low_a: assert property (!s_r.gate && s_nxt.burst_rem == 2'h0 |=> !s_r.pin)
    else $error("pin high with gate and burst off");
  gate_pass_a: assert property (s_r.gate_act && s_r.gate && car.carrier |=> s_r.pin)
    else $error("gated carrier not on pin");
  gate_sync_a: assert property ($rose(s_r.gate_act) |-> $past(car.period_start))
    else $error("gate opened mid period");
  init_hold_a: assert property (s_r.init_cnt != 6'h00 |-> s_r.on)
    else $error("on bit cleared during init");
  start_gen_a: assert property (s_r.on && !car.running |=> car.running)
    else $error("generator did not start");
  burst_edge_a: assert property ($rose(s_r.burst_rem != 2'h0) |-> $past(car.tau_start))
    else $error("burst began off a reference edge");
  reset_vals_a: assert property (!$past(rst_n_i) |-> !s_r.gate && s_r.on && !s_r.pin)
    else $error("wrong values after reset");

  gate_out_c: cover property (s_r.gate_act && s_r.pin);
  burst_out_c: cover property (s_r.burst_rem == 2'h3 && s_r.pin);
  wr_resp_c: cover property (s_r.bvalid && s_axi_bready_i);
  rd_resp_c: cover property (s_r.rvalid && s_axi_rready_i);

endmodule : irc_top

`default_nettype wire

// [tb/ir_carrier_generator_test.sv]
`timescale 1ns/1ps
`default_nettype none

module ir_carrier_generator_test
  import irc_pkg::*;
;
  typedef struct packed {
    logic       psel;
    logic [3:0] duty;
    logic [7:0] hi;
    logic [7:0] per;
  } irc_row_t;
  typedef struct packed {
    logic [1:0] tsel;
    logic [1:0] len;
    logic [7:0] ratio;
  } irc_burst_t;

  localparam irc_row_t ROWS [11] = '{
    '{1'b0, 4'h0, 8'h08, 8'h40}, '{1'b0, 4'h1, 8'h10, 8'h40}, '{1'b0, 4'h2, 8'h18, 8'h40},
    '{1'b0, 4'h3, 8'h20, 8'h40}, '{1'b0, 4'h4, 8'h20, 8'h40}, '{1'b0, 4'hf, 8'h20, 8'h40},
    '{1'b1, 4'h0, 8'h04, 8'h60}, '{1'b1, 4'h5, 8'h18, 8'h60}, '{1'b1, 4'hb, 8'h30, 8'h60},
    '{1'b1, 4'hc, 8'h00, 8'h60}, '{1'b1, 4'hf, 8'h00, 8'h60}};
  localparam irc_burst_t BURSTS [5] = '{
    '{2'h0, 2'h3, 8'h0c}, '{2'h1, 2'h2, 8'h10}, '{2'h2, 2'h1, 8'h14},
    '{2'h3, 2'h1, 8'h20}, '{2'h0, 2'h0, 8'h0c}};

  // ============================================================
  // clock, design and load
  // ============================================================
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic [3:0]  awaddr  = 4'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hf;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b1;
  logic [3:0]  araddr  = 4'h0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b1;
  logic        clr     = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, pin;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rv, cfg, last_cfg, snap;
  logic [15:0] pulses;
  logic [7:0]  hi_min, hi_max, per;
  int          error_cnt   = 0;
  int          checks_done = 0;

  // the fast oscillator runs from time zero, long before any output
  initial begin
    forever #5 clk = ~clk;
  end

  irc_top i_irc_top (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ir_tx_pin_o(pin));

  irc_led_model i_irc_led_model (.clk_i(clk), .drive_i(pin), .clr_i(clr), .pulses_o(pulses),
    .hi_min_o(hi_min), .hi_max_o(hi_max), .per_o(per));

  // ============================================================
  // bus and check tasks
  // ============================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
  endtask : rd

  function automatic logic [31:0] cw(input logic on, input logic gt, input logic ps,
                                     input logic [3:0] du, input logic [1:0] ts);
    cw = {22'h00_0000, ts, du, 1'b0, ps, gt, on};
  endfunction : cw

  task automatic stop();
    int n;
    wr(REG_CTRL, last_cfg);
    rd(REG_STATUS);
    chk(32'(rv[0]), 32'h0000_0001, "stop deferred to reference edge");
    n = 0;
    while (rv[0] !== 1'b0 && n < 60) begin
      repeat (64) @(posedge clk);
      rd(REG_STATUS);
      n++;
    end
    chk(32'(rv[0]), 32'h0000_0000, "generator stopped");
    chk(32'(pin), 32'h0000_0000, "pin low while stopped");
  endtask : stop

  task automatic clr_led();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clr_led

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(pin), 32'h0000_0000, "pin in reset");
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL);
    chk(rv, 32'h0000_0001, "control reset value");
    chk(32'(rs), 32'(RESP_OKAY), "control read response");
    rd(REG_STATUS);
    chk(32'(rv[3]), 32'h0000_0001, "init busy after reset");
  endtask : do_reset

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ============================================================
  // tests
  // ============================================================
  initial begin
    @(posedge clk);
    do_reset();
    wr(REG_CTRL, 32'h0000_0000);
    rd(REG_CTRL);
    chk(32'(rv[0]), 32'h0000_0001, "early clear refused");
    wr(4'hc, 32'h0000_0005);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    rd(4'hc);
    chk(rv, 32'h0000_0000, "unmapped read");
    repeat (40) @(posedge clk);
    last_cfg = 32'h0000_0000;
    $display("test reset done");
    foreach (ROWS[i]) begin
      stop();
      cfg = cw(1'b0, 1'b0, ROWS[i].psel, ROWS[i].duty, 2'h0);
      wr(REG_CTRL, cfg);
      wr(REG_CTRL, cfg | 32'h0000_0001);
      clr_led();
      wr(REG_CTRL, cfg | 32'h0000_0003);
      repeat (5 * int'(ROWS[i].per)) @(posedge clk);
      if (ROWS[i].hi == 8'h00) begin
        chk(32'(pulses), 32'h0000_0000, "output suppressed");
      end else begin
        chk(32'(hi_min), 32'(ROWS[i].hi), "first pulse whole");
        chk(32'(hi_max), 32'(ROWS[i].hi), "high time");
        chk(32'(per), 32'(ROWS[i].per), "carrier period");
      end
      rd(REG_CTRL);
      chk(rv, cfg | 32'h0000_0003, "settings kept");
      rd(REG_STATUS);
      chk(rv & 32'h0000_000d, 32'h0000_0001, "status while gated");
      wr(REG_CTRL, cfg | 32'h0000_0001);
      repeat (2) @(posedge clk);
      snap = 32'(pulses);
      repeat (200) @(posedge clk);
      chk(32'(pulses), snap, "gate closed, no pulses");
      chk(32'(pin), 32'h0000_0000, "gate closed, pin low");
      last_cfg = cfg;
      $display("test carrier row %0d done", i);
    end
    foreach (BURSTS[i]) begin
      stop();
      cfg = cw(1'b0, 1'b0, 1'b0, 4'h0, BURSTS[i].tsel);
      wr(REG_CTRL, cfg);
      wr(REG_CTRL, cfg | 32'h0000_0001);
      clr_led();
      rd(REG_CTRL);
      chk(rv, cfg | 32'h0000_0001, "ratio select kept");
      wr(REG_BURST, {30'h0, BURSTS[i].len});
      chk(32'(rs), 32'(RESP_OKAY), "burst write response");
      repeat ((int'(BURSTS[i].len) + 2) * int'(BURSTS[i].ratio) * 64 + 64) @(posedge clk);
      chk(32'(pulses), 32'(BURSTS[i].len) * 32'(BURSTS[i].ratio), "burst");
      last_cfg = cfg;
      $display("test burst row %0d done", i);
    end
    wr(REG_CTRL, cw(1'b1, 1'b1, 1'b0, 4'h2, 2'h0));
    repeat (200) @(posedge clk);
    do_reset();
    $display("test reset in mid-run done");
    results();
  end

  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule : ir_carrier_generator_test

`default_nettype wire

// [tb/irc_led_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// infrared led behind its driver transistor
// ============================================================
// a passive load: it only records what the pin drives, so it cannot hide a fault
module irc_led_model (
  input  wire logic        clk_i,
  input  wire logic        drive_i,
  input  wire logic        clr_i,
  output logic      [15:0] pulses_o,
  output logic      [7:0]  hi_min_o,
  output logic      [7:0]  hi_max_o,
  output logic      [7:0]  per_o
);
  logic       prev_r;
  logic [7:0] hi_r;
  logic [7:0] per_r;

  always_ff @(posedge clk_i) begin
    prev_r <= drive_i;
    if (clr_i) begin
      pulses_o <= 16'h0000;
      hi_min_o <= 8'hff;
      hi_max_o <= 8'h00;
      per_o    <= 8'h00;
      hi_r     <= 8'h00;
      per_r    <= 8'h00;
    end else begin
      per_r <= per_r + 8'h01;
      hi_r  <= hi_r + 8'h01;
      if (drive_i && !prev_r) begin
        pulses_o <= pulses_o + 16'h0001;
        per_o    <= per_r;
        per_r    <= 8'h01;
        hi_r     <= 8'h01;
      end
      if (!drive_i && prev_r) begin
        if (hi_r < hi_min_o) begin
          hi_min_o <= hi_r;
        end
        if (hi_r > hi_max_o) begin
          hi_max_o <= hi_r;
        end
      end
    end
  end
endmodule : irc_led_model

`default_nettype wire
